// file: verilog/hwd_watchdog.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Reset leaves watchdog disarmed, counter held.
// - Writing 1E then E1 arms it.
// - Armed counter advances every 2**sel machine cycles.
// - Software cannot disarm once armed.
// - Repeating the key pair restarts count.
// - Counter at 3FFF overflows, resets device.
// - Overflow drives 96-cycle high reset pulse.
// - Key register write-only, counter unreadable.
// - Seven-bit prescaler stretches timeout, selectable.
module hwd_watchdog #(
	parameter int CNT_W = hwd_pkg::CNT_W,
	parameter int PSC_W = hwd_pkg::PSC_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [hwd_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [hwd_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [hwd_pkg::DATA_W-1:0] prdata_o,
	output logic pslverr_o,
	output logic armed_o,
	output logic rst_pin_o
);
	import hwd_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	hwd_state_e state_q;
	hwd_state_e state_d;
	logic [PULSE_W-1:0] pcnt_q;
	logic [PULSE_W-1:0] pcnt_d;
	logic armed_q;
	logic armed_d;
	logic pin_q;
	logic pin_d;
	logic fired_q;
	logic fired_d;
	logic [SEL_W-1:0] sel_q;
	logic [SEL_W-1:0] sel_d;

	logic pready_q;
	logic pready_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;

	logic acc;
	logic ack;
	logic lane0;
	logic hit;
	logic [DATA_W-1:0] rdata;
	logic key_wr;
	logic cfg_wr;
	logic stat_clr;
	logic key_done;
	logic key_flush;
	logic cnt_run;
	logic cnt_ovf;
	logic [CNT_W-1:0] cnt_val;

	// ************************************************************
	// APB slave
	// ************************************************************
	// One wait state: pready rises one cycle into the access phase
	assign acc = psel_i && penable_i;
	assign ack = acc && pready_q;
	assign lane0 = pstrb_i[0];

	// Writes act only at the completing edge of the access phase
	assign key_wr = ack && pwrite_i && lane0 && (paddr_i == KEY_ADDR);
	assign cfg_wr = ack && pwrite_i && lane0 && (paddr_i == CFG_ADDR);
	assign stat_clr = ack && pwrite_i && lane0 && (paddr_i == STAT_ADDR)
		&& pwdata_i[STAT_FIRED_BIT];

	always_comb begin
		rdata = '0;
		hit = 1'b0;
		if (paddr_i == KEY_ADDR) begin
			// Key register reads back zero, counter has no read path
			hit = 1'b1;
		end else if (paddr_i == CFG_ADDR) begin
			hit = 1'b1;
			rdata[CFG_SEL_LSB +: SEL_W] = sel_q;
		end else if (paddr_i == STAT_ADDR) begin
			hit = 1'b1;
			rdata[STAT_ARMED_BIT] = armed_q;
			rdata[STAT_PULSE_BIT] = pin_q;
			rdata[STAT_FIRED_BIT] = fired_q;
		end
	end

	always_comb begin
		pready_d = acc && !pready_q;
		prdata_d = '0;
		pslverr_d = 1'b0;
		if (acc && !pready_q) begin
			pslverr_d = !hit;
			if (!pwrite_i) begin
				prdata_d = rdata;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (ce_i) begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign pready_o = pready_q;
	assign prdata_o = prdata_q;
	assign pslverr_o = pslverr_q;

	// ************************************************************
	// Configuration
	// ************************************************************
	// Timeout select may change while armed; it takes effect at the next tap
	always_comb begin
		sel_d = sel_q;
		if (cfg_wr) begin
			sel_d = pwdata_i[CFG_SEL_LSB +: SEL_W];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sel_q <= CFG_SEL_RST;
		end else if (ce_i) begin
			sel_q <= sel_d;
		end
	end

	// ************************************************************
	// Key detector and counter
	// ************************************************************
	// Keys written while the reset pulse runs are dropped
	assign key_flush = (state_q == ST_PULSE) || cnt_ovf;
	assign cnt_run = (state_q == ST_ARMED);

	hwd_key_seq u_key (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.flush_i(key_flush),
		.wr_i(key_wr),
		.data_i(pwdata_i[7:0]),
		.done_o(key_done)
	);

	hwd_wdt_cnt #(
		.CNT_W(CNT_W),
		.PSC_W(PSC_W)
	) u_cnt (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.run_i(cnt_run),
		.restart_i(key_done),
		.sel_i(sel_q),
		.cnt_o(cnt_val),
		.ovf_o(cnt_ovf)
	);

	// ************************************************************
	// Arming and reset pulse
	// ************************************************************
	always_comb begin
		state_d = state_q;
		pcnt_d = pcnt_q;
		fired_d = fired_q;
		if (stat_clr) begin
			fired_d = 1'b0;
		end
		case (state_q)
			ST_OFF: begin
				if (key_done) begin
					state_d = ST_ARMED;
				end
			end
			ST_ARMED: begin
				// No write path leads back to ST_OFF
				if (cnt_ovf) begin
					state_d = ST_PULSE;
					pcnt_d = '0;
					fired_d = 1'b1;
				end
			end
			ST_PULSE: begin
				if (pcnt_q == PULSE_LAST) begin
					state_d = ST_OFF;
				end else begin
					pcnt_d = pcnt_q + 1'b1;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		armed_d = (state_d == ST_ARMED);
		pin_d = (state_d == ST_PULSE);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_OFF;
			pcnt_q <= '0;
			fired_q <= 1'b0;
			armed_q <= 1'b0;
			pin_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			pcnt_q <= pcnt_d;
			fired_q <= fired_d;
			armed_q <= armed_d;
			pin_q <= pin_d;
		end
	end

	assign armed_o = armed_q;
	assign rst_pin_o = pin_q;

	// ************************************************************
	// Checks
	// ************************************************************
	logic [PULSE_W:0] hi_len_q;
	logic [7:0] last_key_q;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			hi_len_q <= '0;
			last_key_q <= '0;
		end else begin
			if (!pin_q) begin
				hi_len_q <= '0;
			end else if (ce_i) begin
				hi_len_q <= hi_len_q + 1'b1;
			end
			if (ce_i && key_wr) begin
				last_key_q <= pwdata_i[7:0];
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_reset_off: assert property (
		$past(rst_n_i) == 1'b0 |-> state_q == ST_OFF && !armed_o && !rst_pin_o
	) else $error("watchdog not disarmed after reset");

	chk_off_held: assert property (
		state_q == ST_OFF |-> cnt_val == '0
	) else $error("counter moved while disarmed");

	chk_arm_key: assert property (
		ce_i && state_q == ST_OFF && key_done |=> armed_o && cnt_val == '0
	) else $error("key pair did not arm watchdog");

	chk_no_disarm: assert property (
		state_q == ST_ARMED && !cnt_ovf |=> state_q == ST_ARMED && armed_o
	) else $error("watchdog left armed state without overflow");

	chk_service_run: assert property (
		ce_i && state_q == ST_ARMED && key_done && !cnt_ovf |=> cnt_val == '0
	) else $error("service did not restart count");

	chk_ovf_pulse: assert property (
		ce_i && cnt_ovf |=> rst_pin_o && !armed_o && fired_q
	) else $error("overflow did not start reset pulse");

	chk_pulse_len: assert property (
		$fell(rst_pin_o) |-> hi_len_q == {1'b0, PULSE_CYC}
	) else $error("reset pulse length wrong");

	chk_key_read: assert property (
		pready_o && !pwrite_i && paddr_i == KEY_ADDR |-> prdata_o == '0 && !pslverr_o
	) else $error("key register read returned data");

	chk_key_order: assert property (
		key_done |-> last_key_q == KEY_FIRST && pwdata_i[7:0] == KEY_SECOND
	) else $error("key completed without direct first byte");

	chk_apb_ready: assert property (
		ce_i && acc && !pready_o |=> pready_o
	) else $error("apb access not answered after one wait");

endmodule : hwd_watchdog
`default_nettype wire

// file: verilog/hwd_pkg.sv
`default_nettype none
package hwd_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Printed offsets are register indexes, byte address is four times that
	localparam logic [7:0] KEY_IDX = 8'ha6;
	localparam logic [7:0] CFG_IDX = 8'ha7;
	localparam logic [7:0] STAT_IDX = 8'ha8;
	localparam logic [ADDR_W-1:0] KEY_ADDR = {2'b00, KEY_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] CFG_ADDR = {2'b00, CFG_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam logic [7:0] KEY_FIRST = 8'h1e;
	localparam logic [7:0] KEY_SECOND = 8'he1;
	localparam int SEL_W = 3;
	localparam int CFG_SEL_LSB = 0;
	localparam logic [SEL_W-1:0] CFG_SEL_RST = 3'h0;
	localparam int STAT_ARMED_BIT = 0;
	localparam int STAT_PULSE_BIT = 1;
	localparam int STAT_FIRED_BIT = 2;

	// ************************************************************
	// Counts
	// ************************************************************
	localparam int CNT_W = 14;
	localparam int PSC_W = 7;
	localparam int PULSE_W = 7;
	// Reset pin pulse length in peripheral clock periods (core_clk here)
	localparam logic [PULSE_W-1:0] PULSE_CYC = 7'h60;
	localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_CYC - 7'h01;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ARMED = 2'b01,
		ST_PULSE = 2'b10
	} hwd_state_e;

endpackage : hwd_pkg
`default_nettype wire

// file: verilog/hwd_key_seq.sv
`timescale 1ns/10ps
`default_nettype none
module hwd_key_seq (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic flush_i,
	input wire logic wr_i,
	input wire logic [7:0] data_i,
	output logic done_o
);
	import hwd_pkg::*;

	logic got_q;
	logic got_d;

	// ************************************************************
	// Two-write key detector
	// ************************************************************
	assign done_o = wr_i && !flush_i && got_q && (data_i == KEY_SECOND);

	always_comb begin
		got_d = got_q;
		if (flush_i) begin
			got_d = 1'b0;
		end else if (wr_i) begin
			// Any other value breaks the pair, so a stray write restarts it
			got_d = (data_i == KEY_FIRST);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			got_q <= 1'b0;
		end else if (ce_i) begin
			got_q <= got_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_key_break: assert property (
		ce_i && wr_i && data_i != KEY_FIRST |=> !got_q && !done_o
	) else $error("key pair not broken by other write");

endmodule : hwd_key_seq
`default_nettype wire

// file: verilog/hwd_wdt_cnt.sv
`timescale 1ns/10ps
`default_nettype none
module hwd_wdt_cnt #(
	parameter int CNT_W = hwd_pkg::CNT_W,
	parameter int PSC_W = hwd_pkg::PSC_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [hwd_pkg::SEL_W-1:0] sel_i,
	output logic [CNT_W-1:0] cnt_o,
	output logic ovf_o
);
	import hwd_pkg::*;

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	logic [PSC_W-1:0] psc_q;
	logic [PSC_W-1:0] psc_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [PSC_W-1:0] mask;
	logic tick;

	// ************************************************************
	// Prescaler tap select
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < PSC_W; gi++) begin : g_mask
			assign mask[gi] = sel_i > SEL_W'(gi);
		end
	endgenerate

	// Tick every 2**sel cycles: low sel bits of the prescaler all ones
	assign tick = run_i && ((psc_q & mask) == mask);
	assign ovf_o = run_i && (cnt_q == CNT_MAX);
	assign cnt_o = cnt_q;

	always_comb begin
		psc_d = psc_q + 1'b1;
		cnt_d = cnt_q;
		if (!run_i || restart_i) begin
			psc_d = '0;
			cnt_d = '0;
		end else if (tick && cnt_q != CNT_MAX) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			psc_q <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			psc_q <= psc_d;
			cnt_q <= cnt_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_count_step: assert property (
		ce_i && tick && !restart_i && cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + 1'b1
	) else $error("counter did not advance on tick");

	chk_psc_gate: assert property (
		ce_i && run_i && !restart_i && (psc_q & mask) != mask |=> cnt_q == $past(cnt_q)
	) else $error("counter advanced between prescaler taps");

endmodule : hwd_wdt_cnt
`default_nettype wire

// file: test/tb_hardware_watchdog_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_hardware_watchdog_timer;
	import hwd_pkg::*;
	// Short counter keeps each timeout to at most 2048 cycles
	localparam int CW = 4;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [DATA_W-1:0] pwdata_i = '0;
	logic [3:0] pstrb_i = 4'hf;
	logic pready_o;
	logic pslverr_o;
	logic armed_o;
	logic rst_pin_o;
	logic [DATA_W-1:0] prdata_o;
	logic [DATA_W-1:0] rd;
	logic er;
	int n_errors = 0;
	int samples_checked = 0;
	bit pend_m = 1'b0;
	bit armed_m = 1'b0;

	hwd_watchdog #(.CNT_W(CW), .PSC_W(PSC_W)) dut (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.pstrb_i(pstrb_i),
		.pready_o(pready_o),
		.prdata_o(prdata_o),
		.pslverr_o(pslverr_o),
		.armed_o(armed_o),
		.rst_pin_o(rst_pin_o)
	);

	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Entered just after a rising edge; returns one idle edge after the release
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= {3'($urandom), 1'b1};
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		// No fixed wait count: only the bench watchdog ends a hang
		@(posedge core_clk_i);
		while (pready_o !== 1'b1) begin
			@(posedge core_clk_i);
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : apb

	task automatic key(input logic [7:0] v);
		apb(1'b1, KEY_ADDR, {24'h0, v});
		if (v == KEY_SECOND && pend_m) begin
			armed_m = 1'b1;
		end
		pend_m = (v == KEY_FIRST);
		@(negedge core_clk_i);
		check(armed_o, armed_m);
		check(rst_pin_o, 1'b0);
		@(posedge core_clk_i);
	endtask : key

	// Arms with prescale select s, then times the overflow and the pin pulse
	task automatic overflow(input int s);
		int t;
		int n;
		int w;
		apb(1'b1, CFG_ADDR, s);
		apb(1'b0, CFG_ADDR, 32'h0);
		check(rd, s);
		key(KEY_FIRST);
		key(KEY_SECOND);
		// Counted from the completing edge: all ones after 2**CW-1 ticks, pulse one edge later
		t = ((2 ** CW - 1) << s) + 1;
		n = 2;
		@(negedge core_clk_i);
		while (rst_pin_o !== 1'b1 && n < 5000) begin
			@(posedge core_clk_i);
			n++;
			@(negedge core_clk_i);
		end
		check(32'(n >= t && n < t + (1 << s)), 32'h1);
		check(armed_o, 1'b0);
		w = 0;
		while (rst_pin_o === 1'b1 && w < 200) begin
			w++;
			@(negedge core_clk_i);
		end
		check(w, 96);
		armed_m = 1'b0;
		pend_m = 1'b0;
		@(posedge core_clk_i);
		apb(1'b0, STAT_ADDR, 32'h0);
		check(rd[STAT_FIRED_BIT], 1'b1);
		apb(1'b1, STAT_ADDR, 32'h1 << STAT_FIRED_BIT);
		apb(1'b0, STAT_ADDR, 32'h0);
		check(rd, 32'h0);
	endtask : overflow

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		void'($urandom(32'ha6ad));
		repeat (20) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (40) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check(armed_o, 1'b0);
		check(rst_pin_o, 1'b0);
		@(posedge core_clk_i);
		apb(1'b0, STAT_ADDR, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, KEY_ADDR, 32'h0);
		check(rd, 32'h0);
		check(er, 1'b0);
		apb(1'b0, CFG_ADDR, 32'h0);
		check(rd, 32'(CFG_SEL_RST));
		apb(1'b1, 12'h000, {24'h0, KEY_FIRST});
		check(er, 1'b1);
		$display("test reset and registers done");
		key(KEY_SECOND);
		key(KEY_FIRST);
		// Random stray value, never one of the two key bytes
		key((8'($urandom) & 8'h7f) | 8'h20);
		key(KEY_SECOND);
		key(KEY_SECOND);
		$display("test wrong key order done");
		// A write to another register between the two keys must not break the pair
		key(KEY_FIRST);
		// Slower tap so the service cadence of the key tasks stays inside the timeout
		apb(1'b1, CFG_ADDR, 32'h3);
		key(KEY_SECOND);
		key(8'h00);
		key(KEY_SECOND);
		repeat (10) begin
			key(KEY_FIRST);
			key(KEY_SECOND);
		end
		$display("test arm and service done");
		// Reset in mid-run while armed must disarm and restore the select
		rst_n_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		armed_m = 1'b0;
		pend_m = 1'b0;
		@(negedge core_clk_i);
		check(armed_o, armed_m);
		check(rst_pin_o, 1'b0);
		@(posedge core_clk_i);
		apb(1'b0, CFG_ADDR, 32'h0);
		check(rd, 32'(CFG_SEL_RST));
		$display("test mid-run reset done");
		for (int s = 0; s < 8; s++) begin
			overflow(s);
		end
		$display("test overflow done");
		end_of_test();
	end

	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule : tb_hardware_watchdog_timer
`default_nettype wire
